// file: qcb_bank.sv
// Top of the channel pair configuration bank behind an Avalon-MM slave.
//
// Functional notes
// - Mute bits 25 and 9; one mutes.
// - Reset leaves both mutes set, rest zero.
// - Local FIFO reset bit gives one pulse.
// - Bits 27 and 11 store global reset enable.
// - Eight-bit time slot per channel half.
// - Reserved bits zero; odd channel low half.
`timescale 1ns/1ps
`default_nettype none
module qcb_bank #(
    parameter int unsigned NUM_WORDS = qcb_pkg::NUM_WORDS  // Channel pair words.
) (
    input  wire logic                     clock,              // 50 MHz register clock.
    input  wire logic                     rst,                // Asynchronous reset, active high.
    input  wire logic [qcb_pkg::ADDR_W-1:0] avs_address,      // Byte address.
    input  wire logic                     avs_read,           // Read request.
    input  wire logic                     avs_write,          // Write request.
    input  wire logic [3:0]               avs_byteenable,     // Byte lanes.
    input  wire logic [31:0]              avs_writedata,      // Write data.
    output logic [31:0]                   avs_readdata,       // Read data.
    output logic                          avs_waitrequest,    // Stall, low when answered.
    output logic                          avs_readdatavalid,  // Read answer pulse.
    output logic [2*NUM_WORDS-1:0]        chan_mute,          // One per channel, 1 = off.
    output logic [2*NUM_WORDS-1:0]        chan_global_en,     // Global FIFO reset enable.
    output logic [2*NUM_WORDS*8-1:0]      chan_slot,          // Time slot per channel.
    output logic [2*NUM_WORDS-1:0]        chan_fifo_reset     // Local FIFO reset pulses.
);

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic logic word_hit(input logic [qcb_pkg::ADDR_W-1:0] addr,
                                      input int unsigned idx);
        logic [31:0] full;
        full = (32'(qcb_pkg::IDX_FIRST) + idx) * 32'h4;
        word_hit = (addr == full[qcb_pkg::ADDR_W-1:0]);
    endfunction : word_hit

    qcb_pkg::qcb_req_t          req;
    logic                       answered;
    logic [NUM_WORDS-1:0]       hit;
    logic [NUM_WORDS-1:0]       wr_en;
    logic [31:0]                next_readdata;
    qcb_pkg::qcb_chan_cfg_t     cfg [2*NUM_WORDS];
    logic [2*NUM_WORDS-1:0]     pulse;

    assign req.address    = avs_address;
    assign req.read       = avs_read;
    assign req.write      = avs_write;
    assign req.byteenable = avs_byteenable;
    assign req.writedata  = avs_writedata;

    // ************************************************************
    // Channel words
    // ************************************************************
    genvar w;
    generate
        for (w = 0; w < NUM_WORDS; w++) begin : g_word
            assign hit[w]   = word_hit(req.address, w);
            assign wr_en[w] = hit[w] && req.write && answered;

            // Odd channel in the low half, even channel in the high half.
            qcb_channel_half u_lower (
                .clock      (clock),
                .rst        (rst),
                .wr_en      (wr_en[w]),
                .wr_half    (req.writedata[15:0]),
                .wr_lanes   (req.byteenable[1:0]),
                .cfg        (cfg[2*w]),
                .fifo_pulse (pulse[2*w])
            );
            qcb_channel_half u_upper (
                .clock      (clock),
                .rst        (rst),
                .wr_en      (wr_en[w]),
                .wr_half    (req.writedata[31:16]),
                .wr_lanes   (req.byteenable[3:2]),
                .cfg        (cfg[2*w+1]),
                .fifo_pulse (pulse[2*w+1])
            );
        end
    endgenerate

    // ************************************************************
    // Bus handshake
    // ************************************************************
    // Each request waits one cycle; waitrequest drops for one cycle to answer.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            answered <= 1'h0;
        end else begin
            answered <= (req.read || req.write) && !answered;
        end
    end

    always_comb begin
        next_readdata = qcb_pkg::UNMAPPED_DATA;
        for (int i = 0; i < NUM_WORDS; i++) begin
            if (hit[i]) begin
                next_readdata = qcb_pkg::WRITABLE_MASK & {
                    4'h0, cfg[2*i+1].global_en, 1'h0, cfg[2*i+1].mute, 1'h0,
                    cfg[2*i+1].slot,
                    4'h0, cfg[2*i].global_en, 1'h0, cfg[2*i].mute, 1'h0,
                    cfg[2*i].slot};
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'h1;
        end else begin
            avs_waitrequest <= !((req.read || req.write) && !answered);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            avs_readdata      <= 32'h0000_0000;
            avs_readdatavalid <= 1'h0;
        end else begin
            avs_readdatavalid <= req.read && !answered;
            if (req.read && !answered) begin
                avs_readdata <= next_readdata;
            end
        end
    end

    // ************************************************************
    // Channel outputs
    // ************************************************************
    genvar c;
    generate
        for (c = 0; c < 2*NUM_WORDS; c++) begin : g_out
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    chan_mute[c]          <= qcb_pkg::MUTE_RESET;
                    chan_global_en[c]     <= qcb_pkg::GLOBAL_EN_RESET;
                    chan_slot[c*8 +: 8]   <= qcb_pkg::SLOT_RESET;
                    chan_fifo_reset[c]    <= 1'h0;
                end else begin
                    chan_mute[c]          <= cfg[c].mute;
                    chan_global_en[c]     <= cfg[c].global_en;
                    chan_slot[c*8 +: 8]   <= cfg[c].slot;
                    chan_fifo_reset[c]    <= pulse[c];
                end
            end
        end
    endgenerate

endmodule : qcb_bank
`default_nettype wire

// file: qcb_bank_bench.sv
// Self-checking bench of the channel pair configuration bank.
`timescale 1ns/1ps
`default_nettype none
module qcb_bank_bench;
    logic              clock = 1'b0;
    logic              rst = 1'b1;
    qcb_pkg::qcb_req_t req = '0;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic              avs_readdatavalid;
    logic [19:0]       chan_mute;
    logic [19:0]       chan_global_en;
    logic [159:0]      chan_slot;
    logic [19:0]       chan_fifo_reset;
    logic [31:0]       rd;
    int                num_errors = 0;
    int                cmp_count = 0;
    int                cycles = 0;
    always #10 clock = ~clock;
    qcb_bank qcb_bank_i (.clock, .rst, .avs_address(req.address), .avs_read(req.read),
        .avs_write(req.write), .avs_byteenable(req.byteenable), .avs_writedata(req.writedata),
        .avs_readdata, .avs_waitrequest, .avs_readdatavalid, .chan_mute, .chan_global_en,
        .chan_slot, .chan_fifo_reset);
    // ************************************************************
    // Bus cycles, comparison and verdict
    // ************************************************************
    task automatic access(input logic [9:0] a, input logic wr, input logic [3:0] be,
                          input logic [31:0] wd);
        @(posedge clock);
        req <= '{address: a, read: !wr, write: wr, byteenable: be, writedata: wd};
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        check("readdatavalid", {31'h0, !wr}, {31'h0, avs_readdatavalid});
        req <= '0;
    endtask : access
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        for (int k = 0; k < 10; k++) begin
            access(10'h238 + 10'(4 * k), 1'b0, 4'h0, 32'h0);
            check("reset word", 32'h0200_0200, rd);
        end
        check("reset mute", 32'h000f_ffff, {12'h0, chan_mute});
        check("reset enables", 32'h0, {12'h0, chan_global_en | chan_fifo_reset});
        check("reset slots", 32'h0, {31'h0, |chan_slot});
        $display("test defaults done");
        for (int k = 0; k < 10; k++) begin
            access(10'h238 + 10'(4 * k), 1'b1, 4'hf, {8'hfc, 8'h40 + 8'(k), 8'hf6, 8'h80 + 8'(k)});
            @(posedge clock);
            #1 check("pulse", 32'h3 << (2 * k), {12'h0, chan_fifo_reset});
            check("mute", 32'h1, {30'h0, chan_mute[2*k+:2]});
            check("global", 32'h2, {30'h0, chan_global_en[2*k+:2]});
            check("slot", {16'h0, 8'h40 + 8'(k), 8'h80 + 8'(k)}, {16'h0, chan_slot[16*k+:16]});
            @(posedge clock);
            #1 check("pulse end", 32'h0, {12'h0, chan_fifo_reset});
            access(10'h238 + 10'(4 * k), 1'b0, 4'h0, 32'h0);
            check("readback", {8'h08, 8'h40 + 8'(k), 8'h02, 8'h80 + 8'(k)}, rd);
        end
        $display("test full words done");
        access(10'h238, 1'b1, 4'h3, 32'hffff_0000);
        access(10'h238, 1'b0, 4'h0, 32'h0);
        check("lane write", 32'h0840_0000, rd);
        check("lane mute", 32'h0, {30'h0, chan_mute[1:0]});
        $display("test byte lanes done");
        access(10'h260, 1'b1, 4'hf, 32'hffff_ffff);
        access(10'h234, 1'b0, 4'h0, 32'h0);
        check("unmapped", 32'h0, rd);
        access(10'h25c, 1'b0, 4'h0, 32'h0);
        check("neighbour", 32'h0849_0289, rd);
        $display("test unmapped done");
        @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        access(10'h244, 1'b0, 4'h0, 32'h0);
        check("second reset", 32'h0200_0200, rd);
        $display("test second reset done");
        tally_and_finish;
    end
endmodule : qcb_bank_bench
`default_nettype wire

// file: qcb_bank_monitor.sv
// Checker of the channel pair bank, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module qcb_bank_monitor #(
    parameter int unsigned NUM_WORDS = qcb_pkg::NUM_WORDS  // Channel pair words.
) (
    input wire logic                         clock,             // Clock.
    input wire logic                         rst,               // Reset.
    input wire logic [qcb_pkg::ADDR_W-1:0]   avs_address,       // Address.
    input wire logic                         avs_read,          // Read.
    input wire logic                         avs_write,         // Write.
    input wire logic [3:0]                   avs_byteenable,    // Lanes.
    input wire logic [31:0]                  avs_writedata,     // Write data.
    input wire logic [31:0]                  avs_readdata,      // Read data.
    input wire logic                         avs_waitrequest,   // Stall.
    input wire logic                         avs_readdatavalid, // Read answer.
    input wire logic [2*NUM_WORDS-1:0]       chan_mute,         // Mutes.
    input wire logic [2*NUM_WORDS-1:0]       chan_global_en,    // Global enables.
    input wire logic [2*NUM_WORDS*8-1:0]     chan_slot,         // Slots.
    input wire logic [2*NUM_WORDS-1:0]       chan_fifo_reset    // Pulses.
);
    // ************************************************************
    // Writes answered to the channel 13 and 14 word
    // ************************************************************
    wire wr0 = avs_write && !avs_waitrequest && avs_address == 10'h238;
    wire pulse_lo_req = wr0 && avs_byteenable[1] && avs_writedata[10];
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    AST_MUTE_HI: assert property (wr0 && avs_byteenable[3] |-> ##2
        chan_mute[1] == $past(avs_writedata[25], 2)) else $error("upper mute wrong");
    AST_MUTE_LO: assert property (wr0 && avs_byteenable[1] |-> ##2
        chan_mute[0] == $past(avs_writedata[9], 2)) else $error("lower mute wrong");
    AST_RESET_DEFAULTS: assert property ($past(rst) |-> avs_waitrequest &&
        &chan_mute && chan_global_en == '0 && chan_slot == '0) else $error("reset state wrong");
    AST_PULSE_ONE: assert property (wr0 && avs_byteenable[3] && avs_writedata[26] |->
        ##2 chan_fifo_reset[1] ##1 !chan_fifo_reset[1]) else $error("pulse not one cycle");
    AST_PULSE_CAUSE: assert property ($rose(chan_fifo_reset[0]) |->
        $past(pulse_lo_req, 2)) else $error("pulse without request");
    AST_GLOBAL_HI: assert property (wr0 && avs_byteenable[3] |-> ##2
        chan_global_en[1] == $past(avs_writedata[27], 2)) else $error("global enable wrong");
    AST_SLOT_LO: assert property (wr0 && avs_byteenable[0] |-> ##2
        chan_slot[7:0] == $past(avs_writedata[7:0], 2)) else $error("slot wrong");
    AST_READ_ZERO: assert property (avs_readdatavalid |->
        (avs_readdata & 32'hf500_f500) == 32'h0) else $error("reserved bits read high");
    cover property (wr0);
    cover property (avs_readdatavalid);
    cover property (chan_fifo_reset[1]);
endmodule : qcb_bank_monitor
bind qcb_bank qcb_bank_monitor #(.NUM_WORDS(NUM_WORDS)) qcb_bank_monitor_i (.clock, .rst,
    .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .avs_readdatavalid, .chan_mute, .chan_global_en, .chan_slot,
    .chan_fifo_reset);
`default_nettype wire

// file: qcb_channel_half.sv
// One channel's settings and its local FIFO reset pulse.
`timescale 1ns/1ps
`default_nettype none
module qcb_channel_half (
    input  wire logic                   clock,      // Register clock.
    input  wire logic                   rst,        // Asynchronous reset, active high.
    input  wire logic                   wr_en,      // Write strobe for this half.
    input  wire logic [15:0]            wr_half,    // Write data for this half.
    input  wire logic [1:0]             wr_lanes,   // Byte enables for this half.
    output qcb_pkg::qcb_chan_cfg_t      cfg,        // Stored settings.
    output logic                        fifo_pulse  // One-cycle local FIFO reset.
);

    // ************************************************************
    // Stored fields
    // ************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg.mute      <= qcb_pkg::MUTE_RESET;
            cfg.global_en <= qcb_pkg::GLOBAL_EN_RESET;
            cfg.slot      <= qcb_pkg::SLOT_RESET;
        end else if (wr_en) begin
            if (wr_lanes[0]) begin
                cfg.slot <= wr_half[qcb_pkg::SLOT_POS +: qcb_pkg::SLOT_W];
            end
            if (wr_lanes[1]) begin
                cfg.mute      <= wr_half[qcb_pkg::MUTE_POS];
                cfg.global_en <= wr_half[qcb_pkg::GLOBAL_EN_POS];
            end
        end
    end

    // ************************************************************
    // Self-clearing local reset
    // ************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fifo_pulse <= 1'h0;
        end else begin
            fifo_pulse <= wr_en && wr_lanes[1] && wr_half[qcb_pkg::LOCAL_RST_POS];
        end
    end

endmodule : qcb_channel_half
`default_nettype wire

// file: qcb_pkg.sv
// Package of constants and types for the channel pair configuration bank.
package qcb_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int unsigned NUM_WORDS        = 10;
    localparam int unsigned FIRST_CHANNEL    = 13;
    localparam logic [7:0]  IDX_PAIR_13_14   = 8'h8e;
    localparam logic [7:0]  IDX_PAIR_15_16   = 8'h8f;
    localparam logic [7:0]  IDX_PAIR_17_18   = 8'h90;
    localparam logic [7:0]  IDX_PAIR_19_20   = 8'h91;
    localparam logic [7:0]  IDX_PAIR_21_22   = 8'h92;
    localparam logic [7:0]  IDX_PAIR_23_24   = 8'h93;
    localparam logic [7:0]  IDX_PAIR_25_26   = 8'h94;
    localparam logic [7:0]  IDX_PAIR_27_28   = 8'h95;
    localparam logic [7:0]  IDX_PAIR_29_30   = 8'h96;
    localparam logic [7:0]  IDX_PAIR_31_32   = 8'h97;
    localparam logic [7:0]  IDX_FIRST        = IDX_PAIR_13_14;
    localparam logic [7:0]  IDX_LAST         = IDX_PAIR_31_32;
    localparam int unsigned ADDR_W           = 10;
    localparam logic [31:0] UNMAPPED_DATA    = 32'h0000_0000;

    // ************************************************************
    // Field layout, per half word
    // ************************************************************
    localparam int unsigned UPPER_BASE       = 16;
    localparam int unsigned LOWER_BASE       = 0;
    localparam int unsigned SLOT_POS         = 0;
    localparam int unsigned SLOT_W           = 8;
    localparam int unsigned MUTE_POS         = 9;
    localparam int unsigned LOCAL_RST_POS    = 10;
    localparam int unsigned GLOBAL_EN_POS    = 11;
    localparam logic [31:0] WRITABLE_MASK    = 32'h0eff_0eff;
    localparam logic [31:0] WORD_RESET       = 32'h0200_0200;
    localparam logic        MUTE_RESET       = 1'h1;
    localparam logic        GLOBAL_EN_RESET  = 1'h0;
    localparam logic [7:0]  SLOT_RESET       = 8'h00;

    // Stored settings of one channel.
    typedef struct packed {
        logic       global_en;
        logic       mute;
        logic [7:0] slot;
    } qcb_chan_cfg_t;

    // Avalon-MM request from the master.
    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [3:0]        byteenable;
        logic [31:0]       writedata;
    } qcb_req_t;

endpackage : qcb_pkg
